// ===== src/rsa_alu.sv
`timescale 1ns/100ps
// Operation
// - rotate left via carry into working register
// - rotate memory right, bit0 wraps, no flags
// - rotate right into working register, no flags
// - rotate memory right through carry
// - rotate right through carry into working register
// - working minus operand minus not-carry to working
// - borrow subtract result goes to memory
// - carry cleared on negative, set otherwise
// - subtractions update all six arithmetic flags
// - decrement memory, skip when zero
// - decrement into working register, skip when zero
// - skip instructions take two cycles
// - byte set all ones, bit set one bit
// - increment memory, skip when zero
// - increment into working register, skip when zero
// - skip when selected bit is one
// - skip when byte nonzero, rewrite byte
// - plain subtract to working register
// - plain subtract result to memory
// - swap memory nibbles, no flags
// - swapped nibbles into working register
// - skip when byte is zero, rewrite byte
module rsa_alu
   import rsa_pkg::*;
(
   input wire logic clock, // core clock
   input wire logic rst, // synchronous reset, high
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   output logic busy, // instruction in flight
   output logic done, // pulse at instruction end
   output logic skip_next // next instruction is skipped
);

   ////////////////////////////////////////////////////////////////////////////
   // bus slave

   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic access;
   logic fire;
   logic hit;
   logic cmd_wr;
   rsa_state_t state_q;
   rsa_cmd_t cmd_q;
   logic [7:0] wreg_q;
   logic [7:0] mem_q;
   rsa_flags_t flags_q;
   logic skip_q;
   logic done_q;

   assign access = psel && penable;
   // one wait state so every answer comes from a flop
   assign fire = access && pready_q;
   assign hit = paddr inside {RSA_CMD_OFS, RSA_WREG_OFS, RSA_MEM_OFS, RSA_FLAGS_OFS,
                              RSA_STAT_OFS};
   // take the command on the error verdict made at the first access edge, so a
   // refused command can never still launch once the dummy cycle ends
   assign cmd_wr = fire && pwrite && paddr == RSA_CMD_OFS && !pslverr_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= access && !pready_q;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (access && !pready_q) begin
         // a command while busy is refused, not queued
         pslverr_q <= !hit || (pwrite && paddr == RSA_CMD_OFS && state_q != ST_IDLE);
         prdata_q <= 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               RSA_CMD_OFS: prdata_q <= {16'h0000, cmd_q};
               RSA_WREG_OFS: prdata_q <= {24'h000000, wreg_q};
               RSA_MEM_OFS: prdata_q <= {24'h000000, mem_q};
               RSA_FLAGS_OFS: prdata_q <= {26'h0000000, flags_q};
               RSA_STAT_OFS: prdata_q <= {30'h00000000, skip_q, state_q != ST_IDLE};
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end else begin
         pslverr_q <= 1'b0;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // datapath

   rsa_op_t op;
   logic [7:0] opnd;
   logic bin;
   logic [8:0] diff;
   logic [4:0] ldiff;
   logic [7:0] w_d;
   logic [7:0] m_d;
   rsa_flags_t f_d;
   rsa_flags_t sub_f;
   logic skip_d;
   logic two_cycle;
   logic is_sub;
   logic chain;
   logic [7:0] inc;
   logic [7:0] dec;

   assign op = rsa_op_t'(cmd_q.op);
   assign inc = mem_q + 8'h01;
   assign dec = mem_q - 8'h01;
   assign is_sub = op inside {minus_with_borrow, minus_with_borrow_imm, minus_with_borrow_to_mem,
                              minus_plain, minus_imm, minus_to_mem};
   assign chain = op inside {minus_with_borrow, minus_with_borrow_imm, minus_with_borrow_to_mem};
   assign opnd = (op inside {minus_with_borrow_imm, minus_imm}) ? cmd_q.imm : mem_q;
   // borrow only for the with-borrow group; plain subtract ignores carry
   assign bin = chain ? !flags_q.carry : 1'b0;
   assign diff = {1'b0, wreg_q} - {1'b0, opnd} - {8'h00, bin};
   assign ldiff = {1'b0, wreg_q[3:0]} - {1'b0, opnd[3:0]} - {4'h0, bin};

   always_comb begin
      sub_f.carry = !diff[8];
      sub_f.half_carry_flag = !ldiff[4];
      sub_f.zero = diff[7:0] == 8'h00;
      sub_f.signed_wrap_flag = (wreg_q[7] ^ opnd[7]) & (wreg_q[7] ^ diff[7]);
      sub_f.sign_compare_flag = sub_f.signed_wrap_flag ^ diff[7];
      // chained zero carries the previous result across multi-byte sequences
      sub_f.chained_zero_flag = chain ? (sub_f.zero & flags_q.chained_zero_flag) : sub_f.zero;
   end

   always_comb begin
      w_d = wreg_q;
      m_d = mem_q;
      f_d = flags_q;
      skip_d = 1'b0;
      two_cycle = 1'b0;
      if (is_sub) begin
         f_d = sub_f;
      end
      unique case (op)
         rotl_thru_carry_to_w: begin
            w_d = {mem_q[6:0], flags_q.carry};
            f_d.carry = mem_q[7];
         end
         rotate_right: m_d = {mem_q[0], mem_q[7:1]};
         rotate_right_to_w: w_d = {mem_q[0], mem_q[7:1]};
         rotate_right_thru_carry: begin
            m_d = {flags_q.carry, mem_q[7:1]};
            f_d.carry = mem_q[0];
         end
         rotate_right_thru_carry_to_w: begin
            w_d = {flags_q.carry, mem_q[7:1]};
            f_d.carry = mem_q[0];
         end
         minus_with_borrow, minus_with_borrow_imm: w_d = diff[7:0];
         minus_with_borrow_to_mem: m_d = diff[7:0];
         minus_plain, minus_imm: w_d = diff[7:0];
         minus_to_mem: m_d = diff[7:0];
         decrement_skip_if_zero: begin
            m_d = dec;
            skip_d = dec == 8'h00;
            two_cycle = 1'b1;
         end
         decrement_skip_if_zero_to_w: begin
            w_d = dec;
            skip_d = dec == 8'h00;
            two_cycle = 1'b1;
         end
         set_byte: m_d = RSA_ALL_ONES;
         set_bit: m_d[cmd_q.bit_sel] = 1'b1;
         increment_skip_if_zero: begin
            m_d = inc;
            skip_d = inc == 8'h00;
            two_cycle = 1'b1;
         end
         increment_skip_if_zero_to_w: begin
            w_d = inc;
            skip_d = inc == 8'h00;
            two_cycle = 1'b1;
         end
         skip_if_bit_nonzero: begin
            skip_d = mem_q[cmd_q.bit_sel];
            two_cycle = 1'b1;
         end
         skip_if_nonzero: begin
            m_d = mem_q;
            skip_d = mem_q != 8'h00;
            two_cycle = 1'b1;
         end
         nibble_exchange: m_d = {mem_q[3:0], mem_q[7:4]};
         nibble_exchange_to_w: w_d = {mem_q[3:0], mem_q[7:4]};
         skip_if_zero: begin
            m_d = mem_q;
            skip_d = mem_q == 8'h00;
            two_cycle = 1'b1;
         end
         // unused opcodes behave as a no-op
         default: w_d = wreg_q;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencing

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: if (cmd_wr) state_q <= ST_EXEC;
            ST_EXEC: state_q <= two_cycle ? ST_DUMMY : ST_IDLE;
            ST_DUMMY: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cmd_q <= RSA_CMD_RST;
      end else if (cmd_wr) begin
         cmd_q <= pwdata[15:0];
      end
   end

   // software writes land only while idle, so they never race a result
   always_ff @(posedge clock) begin
      if (rst) begin
         wreg_q <= RSA_WREG_RST;
      end else if (state_q == ST_EXEC) begin
         wreg_q <= w_d;
      end else if (fire && pwrite && paddr == RSA_WREG_OFS && state_q == ST_IDLE) begin
         wreg_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         mem_q <= RSA_MEM_RST;
      end else if (state_q == ST_EXEC) begin
         mem_q <= m_d;
      end else if (fire && pwrite && paddr == RSA_MEM_OFS && state_q == ST_IDLE) begin
         mem_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         flags_q <= RSA_FLAGS_RST;
      end else if (state_q == ST_EXEC) begin
         flags_q <= f_d;
      end else if (fire && pwrite && paddr == RSA_FLAGS_OFS && state_q == ST_IDLE) begin
         flags_q <= pwdata[5:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         skip_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         if (state_q == ST_EXEC) begin
            skip_q <= skip_d;
         end else if (cmd_wr) begin
            skip_q <= 1'b0;
         end
         done_q <= (state_q == ST_EXEC && !two_cycle) || state_q == ST_DUMMY;
      end
   end

   logic busy_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= cmd_wr || (state_q == ST_EXEC && two_cycle);
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign skip_next = skip_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   chk_rotl_carry: assert property (
      state_q == ST_EXEC && op == rotl_thru_carry_to_w |=>
      wreg_q == {$past(mem_q[6:0]), $past(flags_q.carry)} && flags_q.carry == $past(mem_q[7])
      && mem_q == $past(mem_q)) else $error("left rotate through carry wrong");
   chk_rotr_mem: assert property (
      state_q == ST_EXEC && op == rotate_right |=>
      mem_q == {$past(mem_q[0]), $past(mem_q[7:1])} && flags_q == $past(flags_q))
      else $error("right rotate of memory wrong");
   chk_rotr_carry: assert property (
      state_q == ST_EXEC && op == rotate_right_thru_carry |=>
      mem_q == {$past(flags_q.carry), $past(mem_q[7:1])} && flags_q.carry == $past(mem_q[0]))
      else $error("right rotate through carry wrong");
   chk_sub_borrow: assert property (
      state_q == ST_EXEC && op == minus_with_borrow |=>
      wreg_q == 8'($past(wreg_q) - $past(mem_q) - {7'h00, !$past(flags_q.carry)}))
      else $error("borrow subtract result wrong");
   chk_sub_carry: assert property (
      state_q == ST_EXEC && op == minus_to_mem |=>
      flags_q.carry == ($past(wreg_q) >= $past(mem_q)) && wreg_q == $past(wreg_q))
      else $error("subtract carry wrong");
   chk_dec_skip: assert property (
      state_q == ST_EXEC && op == decrement_skip_if_zero |=>
      mem_q == 8'($past(mem_q) - 8'h01) && skip_q == (mem_q == 8'h00))
      else $error("decrement skip wrong");
   chk_skip_two: assert property (
      cmd_wr && rsa_op_t'(pwdata[4:0]) inside {skip_if_zero, skip_if_nonzero} |=>
      !done_q ##1 !done_q ##1 done_q) else $error("skip not two cycles");
   chk_inc_w: assert property (
      state_q == ST_EXEC && op == increment_skip_if_zero_to_w |=>
      wreg_q == 8'($past(mem_q) + 8'h01) && mem_q == $past(mem_q) && flags_q == $past(flags_q))
      else $error("increment to working register wrong");
   chk_bit_skip: assert property (
      state_q == ST_EXEC && op == skip_if_bit_nonzero |=>
      skip_q == $past(mem_q[cmd_q.bit_sel])) else $error("bit skip wrong");
   chk_swap_mem: assert property (
      state_q == ST_EXEC && op == nibble_exchange |=>
      mem_q == {$past(mem_q[3:0]), $past(mem_q[7:4])}) else $error("nibble swap wrong");

   cov_skip_taken: cover property (state_q == ST_EXEC && two_cycle && skip_d);
   cov_sub_neg: cover property (state_q == ST_EXEC && is_sub && diff[8]);
   cov_busy_cmd: cover property (fire && pwrite && paddr == RSA_CMD_OFS && pslverr_q);

endmodule

// ===== include/rsa_pkg.sv
package rsa_pkg;

   // register byte addresses on the bus
   localparam logic [7:0] RSA_CMD_OFS = 8'h00;
   localparam logic [7:0] RSA_WREG_OFS = 8'h04;
   localparam logic [7:0] RSA_MEM_OFS = 8'h08;
   localparam logic [7:0] RSA_FLAGS_OFS = 8'h0c;
   localparam logic [7:0] RSA_STAT_OFS = 8'h10;

   // command word fields
   localparam int RSA_OP_LSB = 0;
   localparam int RSA_BIT_LSB = 5;
   localparam int RSA_IMM_LSB = 8;

   // reset values
   localparam logic [7:0] RSA_WREG_RST = 8'h00;
   localparam logic [7:0] RSA_MEM_RST = 8'h00;
   localparam logic [15:0] RSA_CMD_RST = 16'h001f;

   // byte-set pattern and skip timing
   localparam logic [7:0] RSA_ALL_ONES = 8'hff;
   localparam int RSA_SKIP_CYCLES = 2;

   typedef enum logic [4:0] {
      rotl_thru_carry_to_w,
      rotate_right,
      rotate_right_to_w,
      rotate_right_thru_carry,
      rotate_right_thru_carry_to_w,
      minus_with_borrow,
      minus_with_borrow_imm,
      minus_with_borrow_to_mem,
      minus_plain,
      minus_imm,
      minus_to_mem,
      decrement_skip_if_zero,
      decrement_skip_if_zero_to_w,
      set_byte,
      set_bit,
      increment_skip_if_zero,
      increment_skip_if_zero_to_w,
      skip_if_bit_nonzero,
      skip_if_nonzero,
      nibble_exchange,
      nibble_exchange_to_w,
      skip_if_zero
   } rsa_op_t;

   typedef struct packed {
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [4:0] op;
   } rsa_cmd_t;

   typedef struct packed {
      logic chained_zero_flag;
      logic sign_compare_flag;
      logic signed_wrap_flag;
      logic zero;
      logic half_carry_flag;
      logic carry;
   } rsa_flags_t;

   localparam rsa_flags_t RSA_FLAGS_RST = '0;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_DUMMY
   } rsa_state_t;

endpackage

// ===== bench/rsa_alu_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
   $display("[ERR] %0t mismatch got %0h exp %0h", $time, (got), (exp)); end end

module rsa_alu_tb
   import rsa_pkg::*;
;
   logic clock;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic busy;
   logic done;
   logic skip_next;
   int errors;
   int cmp_count;
   logic [31:0] rd;
   logic e;
   logic [15:0] corner [4] = '{16'h0000, 16'h8001, 16'h7fff, 16'h0080};

   rsa_alu i_dut (
      .clock(clock),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .busy(busy),
      .done(done),
      .skip_next(skip_next)
   );

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // expected results
   function automatic logic [7:0] sub(input logic [7:0] a, input logic [7:0] o,
                                      input logic wb, inout rsa_flags_t f);
      logic nc;
      logic [8:0] d;
      logic [4:0] h;
      nc = wb ? ~f.carry : 1'b0;
      d = {1'b0, a} - {1'b0, o} - {8'h00, nc};
      h = {1'b0, a[3:0]} - {1'b0, o[3:0]} - {4'h0, nc};
      f.carry = ~d[8];
      f.half_carry_flag = ~h[4];
      f.zero = (d[7:0] == 8'h00);
      f.signed_wrap_flag = (a[7] != o[7]) && (d[7] != a[7]);
      f.sign_compare_flag = f.signed_wrap_flag ^ d[7];
      // borrow variants chain the zero test across bytes
      f.chained_zero_flag = wb ? (f.zero & f.chained_zero_flag) : f.zero;
      return d[7:0];
   endfunction

   function automatic logic is_skip(input logic [4:0] op);
      return rsa_op_t'(op) inside {decrement_skip_if_zero, decrement_skip_if_zero_to_w,
         increment_skip_if_zero, increment_skip_if_zero_to_w, skip_if_bit_nonzero,
         skip_if_nonzero, skip_if_zero};
   endfunction

   function automatic void model(input logic [4:0] op, input logic [2:0] b, input logic [7:0] imm,
                                 inout logic [7:0] w, inout logic [7:0] m, inout rsa_flags_t f,
                                 output logic sk);
      logic [7:0] t;
      sk = 1'b0;
      t = m;
      case (rsa_op_t'(op))
         rotl_thru_carry_to_w: begin
            w = {t[6:0], f.carry};
            f.carry = t[7];
         end
         rotate_right: m = {t[0], t[7:1]};
         rotate_right_to_w: w = {t[0], t[7:1]};
         rotate_right_thru_carry: begin
            m = {f.carry, t[7:1]};
            f.carry = t[0];
         end
         rotate_right_thru_carry_to_w: begin
            w = {f.carry, t[7:1]};
            f.carry = t[0];
         end
         minus_with_borrow: w = sub(w, t, 1'b1, f);
         minus_with_borrow_imm: w = sub(w, imm, 1'b1, f);
         minus_with_borrow_to_mem: m = sub(w, t, 1'b1, f);
         minus_plain: w = sub(w, t, 1'b0, f);
         minus_imm: w = sub(w, imm, 1'b0, f);
         minus_to_mem: m = sub(w, t, 1'b0, f);
         decrement_skip_if_zero: m = t - 8'h01;
         decrement_skip_if_zero_to_w: w = t - 8'h01;
         set_byte: m = RSA_ALL_ONES;
         set_bit: m[b] = 1'b1;
         increment_skip_if_zero: m = t + 8'h01;
         increment_skip_if_zero_to_w: w = t + 8'h01;
         skip_if_bit_nonzero: sk = t[b];
         skip_if_nonzero: sk = (t != 8'h00);
         nibble_exchange: m = {t[3:0], t[7:4]};
         nibble_exchange_to_w: w = {t[3:0], t[7:4]};
         skip_if_zero: sk = (t == 8'h00);
         default: ;
      endcase
      if (rsa_op_t'(op) inside {decrement_skip_if_zero, increment_skip_if_zero}) begin
         sk = (m == 8'h00);
      end
      if (rsa_op_t'(op) inside {decrement_skip_if_zero_to_w, increment_skip_if_zero_to_w}) begin
         sk = (w == 8'h00);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // bus master: setup, access, hold until pready seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         $display("[ERR] %0t no bus answer", $time);
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] imm,
                      input logic [7:0] w0, input logic [7:0] m0, input rsa_flags_t f0);
      logic [7:0] w;
      logic [7:0] m;
      rsa_flags_t f;
      logic sk;
      rsa_cmd_t c;
      int n;
      w = w0;
      m = m0;
      f = f0;
      c = '{imm: imm, bit_sel: b, op: op};
      model(op, b, imm, w, m, f, sk);
      apb(1'b1, RSA_WREG_OFS, {24'h0, w0}, rd, e);
      apb(1'b1, RSA_MEM_OFS, {24'h0, m0}, rd, e);
      apb(1'b1, RSA_FLAGS_OFS, {26'h0, f0}, rd, e);
      apb(1'b1, RSA_CMD_OFS, {16'h0, c}, rd, e);
      n = 0;
      do begin
         @(posedge clock);
         n++;
         // busy stands from the take edge; skip ops hold it through the dummy cycle
         if (n == 1 || (n == 2 && is_skip(op))) `CHK(busy, 1'b1)
      end while (done !== 1'b1 && n < 10);
      `CHK(n, 1 + (is_skip(op) ? RSA_SKIP_CYCLES : 1))
      `CHK(skip_next, sk)
      apb(1'b0, RSA_WREG_OFS, 32'h0, rd, e);
      `CHK(rd[7:0], w)
      `CHK(rd[31:8], 24'h0)
      apb(1'b0, RSA_MEM_OFS, 32'h0, rd, e);
      `CHK(rd[7:0], m)
      `CHK(rd[31:8], 24'h0)
      apb(1'b0, RSA_FLAGS_OFS, 32'h0, rd, e);
      `CHK(rd[5:0], f)
      `CHK(rd[31:6], 26'h0)
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // about 250 instructions of some 30 cycles each
   initial begin
      #(8 * 20000);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim;
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      errors = 0;
      cmp_count = 0;
      void'($urandom(43));
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, RSA_CMD_OFS, 32'h0, rd, e);
      `CHK(rd, {16'h0, RSA_CMD_RST})
      apb(1'b0, RSA_WREG_OFS, 32'h0, rd, e);
      `CHK(rd, {24'h0, RSA_WREG_RST})
      apb(1'b0, RSA_MEM_OFS, 32'h0, rd, e);
      `CHK(rd, {24'h0, RSA_MEM_RST})
      apb(1'b0, RSA_FLAGS_OFS, 32'h0, rd, e);
      `CHK(rd, {26'h0, RSA_FLAGS_RST})
      $display("test reset_values done");
      apb(1'b1, 8'h14, $urandom, rd, e);
      `CHK(e, 1'b1)
      apb(1'b0, 8'h14, 32'h0, rd, e);
      `CHK(e, 1'b1)
      `CHK(rd, 32'h0)
      // status is read-only: write is dropped without error
      apb(1'b1, RSA_STAT_OFS, 32'hffffffff, rd, e);
      `CHK(e, 1'b0)
      apb(1'b0, RSA_STAT_OFS, 32'h0, rd, e);
      `CHK(rd, 32'h0)
      $display("test bus_access done");
      for (int op = 0; op < 24; op++) begin
         for (int k = 0; k < 4; k++) begin
            run(5'(op), 3'(k * 5), corner[k][7:0], corner[k][15:8], corner[k][7:0],
                rsa_flags_t'(k[0] ? 6'h3f : 6'h00));
         end
      end
      $display("test corner_ops done");
      repeat (150) begin
         run(5'($urandom % 24), 3'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
             rsa_flags_t'(6'($urandom)));
      end
      $display("test random_ops done");
      end_sim;
   end
endmodule
